// ==== clk_gate_dec.sv ====
// decodes which peripheral clocks run from oscillator state and selects
module clk_gate_dec
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // decoder side
  gate_if.dec       g
);

  logic [5:0] en_next;

  function automatic logic [1:0] field(input logic [9:0] s, input int lsb);
    field = s[lsb +: 2];
  endfunction : field

  always_comb
  begin
    // order: core, counter a, counter b, timer zero, timer one, serial
    en_next = 6'h3F;
    if (g.halted)
    begin
      en_next[0] = 1'b0;
      if (!g.hs_run)
      begin
        en_next[1] = field(g.sel, halt_pkg::SEL_CNTA_LSB) == halt_pkg::SRC_EXTPIN;
        en_next[2] = field(g.sel, halt_pkg::SEL_CNTB_LSB) == halt_pkg::SRC_EXTPIN;
        en_next[3] = (field(g.sel, halt_pkg::SEL_T0_LSB) == halt_pkg::SRC_EXTPIN) && en_next[1] && g.cnta_run;
        en_next[4] = g.int_run && (field(g.sel, halt_pkg::SEL_T1_LSB) == halt_pkg::SRC_PRESCALE);
        en_next[5] = field(g.sel, halt_pkg::SEL_SER_LSB) == halt_pkg::SRC_EXTPIN;
      end
      else if (!g.int_run)
      begin
        en_next[4] = field(g.sel, halt_pkg::SEL_T1_LSB) == halt_pkg::SRC_HISPEED;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      g.en <= 6'h3F;
    else
      g.en <= en_next;
  end

  core_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    g.halted |=> !g.en[0]) else $error("core clock runs in halt");
  cnta_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g.halted && !g.hs_run && g.sel[1:0] != halt_pkg::SRC_EXTPIN) |=> !g.en[1])
    else $error("counter a runs without pin");
  cntb_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g.halted && !g.hs_run && g.sel[3:2] != halt_pkg::SRC_EXTPIN) |=> !g.en[2])
    else $error("counter b runs without pin");
  t0_chain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g.halted && !g.hs_run && !g.cnta_run) |=> !g.en[3]) else $error("timer zero runs unchained");
  t1_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g.halted && !g.hs_run && !g.int_run) |=> !g.en[4]) else $error("timer one runs, no oscillator");
  ser_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g.halted && !g.hs_run && g.sel[9:8] != halt_pkg::SRC_EXTPIN) |=> !g.en[5])
    else $error("serial port runs on internal clock");

endmodule : clk_gate_dec

// ==== gate_if.sv ====
// carries oscillator state and clock selects to the gating decoder
interface gate_if;
  logic       hs_run;
  logic       int_run;
  logic       halted;
  logic       cnta_run;
  logic [9:0] sel;
  logic [5:0] en;

  modport ctrl (output hs_run, int_run, halted, cnta_run, sel, input en);
  modport dec  (input hs_run, int_run, halted, cnta_run, sel, output en);
endinterface : gate_if

// ==== halt_clk_ctrl.sv ====
// halt-mode clock gating top with apb control registers
//
// The placing of the registers and the APB register port were chosen for this implementation.
module halt_clk_ctrl
#(
  parameter bit INT_STOP_ALLOWED = 1'b0
)
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // processor side
  input  wire logic        halt_exec,
  input  wire logic        irq_pending,
  input  wire logic        irq_masked,
  output logic             wake_vector,
  output logic             resume,
  // gated clock enables
  output logic             core_clk_en,
  output logic             cnta_clk_en,
  output logic             cntb_clk_en,
  output logic             aux_timer_zero_en,
  output logic             aux_timer_one_en,
  output logic             clocked_serial_port_en
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]           ctrl_reg;
  logic [halt_pkg::SEL_W-1:0] sel_reg;
  halt_pkg::halt_state_t state_reg;
  logic [3:0]            wait_reg;
  logic                  opt_stop_reg;
  logic                  vec_reg;
  logic                  wr_en;
  logic                  rd_hit;
  logic [31:0]           rd_next;
  gate_if                g ();

  // option latched from strap after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opt_stop_reg <= 1'b0;
    else
      opt_stop_reg <= INT_STOP_ALLOWED;
  end

  ////////////////////////////////////////////////////////////////////////
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_hit  = (paddr == halt_pkg::CTRL_OFS) || (paddr == halt_pkg::SEL_OFS) ||
                   (paddr == halt_pkg::STATUS_OFS);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= halt_pkg::CTRL_RST;
    else if (wr_en && paddr == halt_pkg::CTRL_OFS)
      ctrl_reg <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= halt_pkg::SEL_RST[halt_pkg::SEL_W-1:0];
    else if (wr_en && paddr == halt_pkg::SEL_OFS)
      sel_reg <= pwdata[halt_pkg::SEL_W-1:0];
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (paddr)
      halt_pkg::CTRL_OFS:   rd_next = ctrl_reg;
      halt_pkg::SEL_OFS:    rd_next = {22'h00_0000, sel_reg};
      halt_pkg::STATUS_OFS: rd_next = {26'h000_0000, g.en};
      default:              rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // halt entry, release, wait, reset ends halt asynchronously
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= halt_pkg::RUN_S;
      wait_reg  <= 4'h0;
      vec_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        halt_pkg::RUN_S:
          if (halt_exec || (wr_en && paddr == halt_pkg::CTRL_OFS && pwdata[halt_pkg::CTRL_HALT]))
            state_reg <= halt_pkg::HALT_S;
        halt_pkg::HALT_S:
          if (irq_pending && !irq_masked)
          begin
            state_reg <= halt_pkg::WAKE_S;
            vec_reg   <= ctrl_reg[halt_pkg::CTRL_IE];
            wait_reg  <= ctrl_reg[halt_pkg::CTRL_IE] ? 4'(halt_pkg::WAIT_VEC_CYC - 1)
                                                     : 4'(halt_pkg::WAIT_NEXT_CYC - 1);
          end
        halt_pkg::WAKE_S:
          if (wait_reg == 4'h0)
            state_reg <= halt_pkg::RUN_S;
          else
            wait_reg <= wait_reg - 4'h1;
        default:
          state_reg <= halt_pkg::RUN_S;
      endcase
    end
  end

  assign resume      = (state_reg == halt_pkg::WAKE_S) && (wait_reg == 4'h0);
  assign wake_vector = vec_reg;

  ////////////////////////////////////////////////////////////////////////
  assign g.hs_run   = !ctrl_reg[halt_pkg::CTRL_HS_STOP];
  // internal stop needs option and software
  assign g.int_run  = !(opt_stop_reg && ctrl_reg[halt_pkg::CTRL_INT_STOP]);
  assign g.halted   = state_reg != halt_pkg::RUN_S;
  assign g.cnta_run = ctrl_reg[halt_pkg::CTRL_CNTA_RUN];
  assign g.sel      = sel_reg;

  clk_gate_dec u_dec
  (
    .pclk    (pclk),
    .presetn (presetn),
    .g       (g)
  );

  assign core_clk_en            = g.en[0];
  assign cnta_clk_en            = g.en[1];
  assign cntb_clk_en            = g.en[2];
  assign aux_timer_zero_en      = g.en[3];
  assign aux_timer_one_en       = g.en[4];
  assign clocked_serial_port_en = g.en[5];

  wake_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(state_reg == halt_pkg::WAKE_S) && vec_reg) |-> ##7 resume)
    else $error("vectored wake wait wrong");
  wake_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(state_reg == halt_pkg::WAKE_S) && !vec_reg) |-> ##1 resume)
    else $error("plain wake wait wrong");
  halt_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == halt_pkg::RUN_S && halt_exec) |=> ##1 !core_clk_en)
    else $error("halt did not stop core");
  mask_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == halt_pkg::HALT_S && irq_masked) |=> state_reg == halt_pkg::HALT_S)
    else $error("masked request left halt");
  resume_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    resume |=> !resume) else $error("resume held too long");

endmodule : halt_clk_ctrl

// ==== halt_pkg.sv ====
// constants and types for the halt-mode clock gating block
//
// What this block does
// - in halt the processor core clock is withheld, execution stops
// - high-speed osc stopped: counter a counts only from its external pin
// - high-speed osc stopped: counter b counts only from its external pin
// - high-speed osc stopped: aux timer zero runs only on running counter a output
// - internal osc stopped: aux timer one runs on high-speed clock only; both stopped, halts
// - only internal osc running: aux timer one runs only on prescaled peripheral clock
// - high-speed osc stopped: serial port runs only from external serial clock
// - internal-osc-stopped cases need option allowing stop and software stop
// - a nonvolatile option chooses whether internal osc may be stopped
// - an unmasked interrupt ends halt; vector if enabled, else next instruction
// - resume delay is 8 clocks vectored, 2 otherwise
// - external reset ends halt with a normal reset
package halt_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] SEL_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // control register fields
  localparam int CTRL_HS_STOP  = 0;
  localparam int CTRL_INT_STOP = 1;
  localparam int CTRL_IE       = 2;
  localparam int CTRL_HALT     = 3;
  localparam int CTRL_CNTA_RUN = 4;

  // select register fields
  localparam int SEL_CNTA_LSB = 0;
  localparam int SEL_CNTB_LSB = 2;
  localparam int SEL_T0_LSB   = 4;
  localparam int SEL_T1_LSB   = 6;
  localparam int SEL_SER_LSB  = 8;
  localparam int SEL_W        = 10;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST  = 32'h0000_0000;

  // clock source codes, two bits per peripheral
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTPIN   = 2'h1;
  localparam logic [1:0] SRC_HISPEED  = 2'h2;
  localparam logic [1:0] SRC_PRESCALE = 2'h3;

  // resume waits in clocks
  localparam int WAIT_VEC_CYC  = 8;
  localparam int WAIT_NEXT_CYC = 2;

  typedef enum logic [1:0] {RUN_S, HALT_S, WAKE_S} halt_state_t;

endpackage : halt_pkg

// ==== tb_top.sv ====
// self-checking testbench for the halt-mode clock gating block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        halt_exec   = 1'b0;
  logic        irq_pending = 1'b0;
  logic        irq_masked  = 1'b0;
  logic        wake_vector;
  logic        resume;
  logic        core_clk_en;
  logic [4:0]  en;
  logic [4:0]  en_fixed;
  int          err_count   = 0;
  int          check_count = 0;

  // enables in order: counter a, counter b, aux timer zero, aux timer one, serial port
  // en_fixed is what the instance whose internal oscillator can never stop should give
  typedef struct {logic [31:0] ctrl; logic [31:0] sel; logic [4:0] en; logic [4:0] en_fixed;} row_t;
  row_t rows [9] = '{
    '{32'h00, 32'h000, 5'h1F, 5'h1F}, '{32'h02, 32'h080, 5'h1F, 5'h1F}, '{32'h02, 32'h000, 5'h1D, 5'h1F},
    '{32'h01, 32'h000, 5'h00, 5'h00}, '{32'h11, 32'h1D5, 5'h1F, 5'h1F}, '{32'h01, 32'h1D5, 5'h1B, 5'h1B},
    '{32'h13, 32'h1D5, 5'h1D, 5'h1F}, '{32'h11, 32'h2AA, 5'h00, 5'h00}, '{32'h00, 32'h2AA, 5'h1F, 5'h1F}};

  halt_clk_ctrl #(.INT_STOP_ALLOWED(1'b1)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .irq_pending(irq_pending), .irq_masked(irq_masked),
    .wake_vector(wake_vector), .resume(resume), .core_clk_en(core_clk_en),
    .cnta_clk_en(en[4]), .cntb_clk_en(en[3]), .aux_timer_zero_en(en[2]),
    .aux_timer_one_en(en[1]), .clocked_serial_port_en(en[0])
  );

  // option cleared: the internal oscillator can never be stopped
  halt_clk_ctrl #(.INT_STOP_ALLOWED(1'b0)) dut_fixed
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .halt_exec(halt_exec), .irq_pending(irq_pending), .irq_masked(irq_masked),
    .wake_vector(), .resume(), .core_clk_en(),
    .cnta_clk_en(en_fixed[4]), .cntb_clk_en(en_fixed[3]), .aux_timer_zero_en(en_fixed[2]),
    .aux_timer_one_en(en_fixed[1]), .clocked_serial_port_en(en_fixed[0])
  );

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH %0t apb answer missing", $time);
      results();
    end
  endtask : apb

  task halt_in();
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask : halt_in

  // raise a request and measure the cycle in which resume shows
  task wake(input int n);
    int i;
    int f;
    @(posedge pclk);
    irq_pending <= 1'b1;
    @(posedge pclk);
    irq_pending <= 1'b0;
    f = 0;
    for (i = 1; i <= 12 && f == 0; i++)
    begin
      #1;
      if (resume === 1'b1)
        f = i;
      @(posedge pclk);
    end
    chk(f, n, "resume delay");
    repeat (3) @(posedge pclk);
    #1;
    chk(core_clk_en, 1'b1, "core clock back");
  endtask : wake

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b1, halt_pkg::SEL_OFS, rows[i].sel, rd, er);
      apb(1'b1, halt_pkg::CTRL_OFS, rows[i].ctrl, rd, er);
      halt_in();
      chk(core_clk_en, 1'b0, "core clock held");
      chk(en, rows[i].en, "peripheral enables");
      chk(en_fixed, rows[i].en_fixed, "enables with fixed option");
      apb(1'b0, halt_pkg::SEL_OFS, 32'h0000_0000, rd, er);
      chk(rd, rows[i].sel, "select kept in halt");
      wake(2);
      chk(wake_vector, 1'b0, "no vector with ie clear");
      chk(en, 5'h1F, "enables outside halt");
    end
    $display("test rows done");
    apb(1'b1, halt_pkg::CTRL_OFS, 32'h0000_0004, rd, er);
    halt_in();
    wake(8);
    chk(wake_vector, 1'b1, "vectored wake");
    halt_in();
    @(posedge pclk);
    irq_masked  <= 1'b1;
    irq_pending <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
    chk(core_clk_en, 1'b0, "masked request holds halt");
    @(posedge pclk);
    irq_pending <= 1'b0;
    irq_masked  <= 1'b0;
    wake(8);
    $display("test release done");
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd, er);
    chk(er, 1'b1, "unmapped write error");
    apb(1'b0, 8'h0C, 32'h0000_0000, rd, er);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0000_0000, "unmapped read data");
    $display("test unmapped done");
    halt_in();
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk({core_clk_en, resume, wake_vector}, 3'b100, "reset frees core");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, halt_pkg::CTRL_OFS, 32'h0000_0000, rd, er);
    chk(rd, halt_pkg::CTRL_RST, "control after reset");
    apb(1'b0, halt_pkg::SEL_OFS, 32'h0000_0000, rd, er);
    chk(rd, halt_pkg::SEL_RST, "select after reset");
    $display("test reset done");
    // halt entry by control register write
    apb(1'b1, halt_pkg::CTRL_OFS, 32'h0000_0008, rd, er);
    repeat (2) @(posedge pclk);
    #1;
    chk(core_clk_en, 1'b0, "register halt stops core");
    wake(2);
    $display("test register halt done");
    results();
  end

  initial
  begin
    repeat (100000) @(posedge pclk);
    err_count++;
    $display("MISMATCH %0t run limit reached", $time);
    results();
  end

endmodule : tb_top
